/* src/prm_cfg.svh */
`ifndef PRM_CFG_SVH
`define PRM_CFG_SVH

// Link widths and table sizes
`define PRM_AW 8
`define PRM_DW 8
`define PRM_N_IN 23
`define PRM_N_PIN 24
`define PRM_N_SRC 28
`define PRM_IN_W 6
`define PRM_OUT_W 5

// Device register map
`define PRM_LOCK_ADDR 8'h00
`define PRM_IN_BASE 8'h20
`define PRM_OUT_BASE 8'h40
`define PRM_LOCK_BIT 0

// Guarded lock sequence keys
`define PRM_KEY1 8'h55
`define PRM_KEY2 8'hAA

// Pin codes: highest valid code, and last code of ports A and B
`define PRM_PIN_LAST 6'h17
`define PRM_INT_LAST 8'h0F

// Interrupt input selector index, and the four I2C clock/data selector indices
`define PRM_INT_IDX 0
`define PRM_I2C0_CLK_IDX 13
`define PRM_I2C0_DAT_IDX 14
`define PRM_I2C1_CLK_IDX 16
`define PRM_I2C1_DAT_IDX 17

// Pins with dedicated I2C buffers: B1, B2, C3, C4
`define PRM_I2C_PIN_MASK 24'h180600

// Input selector reset values, index 22 down to 0
`define PRM_IN_DEFAULTS {6'h0E, 6'h0F, 6'h16, 6'h17, 6'h08, 6'h0A, 6'h09, 6'h05, 6'h14, 6'h13, 6'h0C, 6'h0F, \
	6'h0E, 6'h01, 6'h00, 6'h08, 6'h11, 6'h12, 6'h13, 6'h0D, 6'h10, 6'h04, 6'h08}

// Ports allowed per input (bit0 A, bit1 B, bit2 C), index 22 down to 0
`define PRM_IN_PORTS {3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6, \
	3'h6, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h5, 3'h6, 3'h5, 3'h3, 3'h3}

// Output selector reset value: port latch
`define PRM_OUT_DEFAULT 5'h00

// Controller register map
`define PRM_H_TGT 8'h00
`define PRM_H_DATA 8'h01
`define PRM_H_SRC 8'h02
`define PRM_H_CMD 8'h03
`define PRM_H_STAT 8'h04
`define PRM_H_RDATA 8'h05

// Controller command bits
`define PRM_CMD_WRITE 0
`define PRM_CMD_READ 1
`define PRM_CMD_LOCK 2
`define PRM_CMD_UNLOCK 3
`define PRM_CMD_PAIR 4

// Controller status bits
`define PRM_ST_BUSY 0
`define PRM_ST_LOCKED 1
`define PRM_ST_REFUSED 2
`define PRM_ST_I2C_ADV 3

`endif

/* src/prm_pkg.sv */
`default_nettype none
package prm_pkg;
	typedef logic [5:0] prm_in_sel_t;
	typedef logic [4:0] prm_out_sel_t;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_KEY1, SEQ_KEY2} prm_seq_t;
	typedef enum logic [2:0] {H_IDLE, H_KEY1, H_KEY2, H_PAIR, H_RWAIT, H_RCAP} prm_host_t;
endpackage
`default_nettype wire

/* src/prm_if.sv */
`include "prm_cfg.svh"
`default_nettype none
interface prm_if;
	logic cfg_wr;
	logic cfg_rd;
	logic [`PRM_AW-1:0] cfg_addr;
	logic [`PRM_DW-1:0] cfg_wdata;
	logic [`PRM_DW-1:0] cfg_rdata;
	logic lock_flag;
	modport device (input cfg_wr, input cfg_rd, input cfg_addr, input cfg_wdata, output cfg_rdata, output lock_flag);
	modport host (output cfg_wr, output cfg_rd, output cfg_addr, output cfg_wdata, input cfg_rdata, input lock_flag);
endinterface
`default_nettype wire

/* src/prm_device.sv */
`include "prm_cfg.svh"
`default_nettype none
// Overview of operation
// RULE1 - One input selector per peripheral input
// RULE2 - Pin codes linear, A0 to C7
// RULE3 - Interrupt selector only gets A/B codes
// RULE4 - One output selector per pin
// RULE5 - Direction bit keeps owning output driver
// RULE6 - Sync USART, I2C override direction
// RULE7 - Only digital signals are routed
// RULE8 - Input and output selection independent
// RULE9 - Bidirectional input and output same pin
// RULE10 - I2C buffers only on B1,B2,C3,C4
// RULE11 - I2C thresholds ignore input level there
// RULE12 - Route I2C only to dedicated pins; controller still writes the selector, sets I2C advisory bit
// RULE13 - Lock flag freezes all selectors
// RULE14 - Lock flag changes only after sequence
// RULE15 - Sequence: 0x55, 0xAA, then flag write
// RULE16 - One-shot config: lock sticks until reset
// RULE17 - Power-on reset restores defaults, drops lock
// RULE18 - Locked selector writes ignored, value kept
// RULE19 - Unsupported input code drives constant zero
module prm_device #(
	parameter int N_IN = `PRM_N_IN,
	parameter int N_PIN = `PRM_N_PIN,
	parameter int N_SRC = `PRM_N_SRC
) (
	input wire logic i_sys_clk, // System clock
	input wire logic i_srst, // Power-on reset, sync, high
	input wire logic i_dev_rst, // Other device reset, sync, high
	input wire logic i_one_shot_lock_cfg, // One-shot lock configuration
	prm_if.device link, // Register link from controller
	input wire logic [N_PIN-1:0] i_pin_in, // Digital pin input levels
	input wire logic [N_PIN-1:0] i_pin_latch, // Port latch per pin
	input wire logic [N_PIN-1:0] i_pin_dir, // Direction control, 1 = input
	input wire logic [N_PIN-1:0] i_input_level_select, // 1 = Schmitt, 0 = TTL
	input wire logic [N_SRC-1:0] i_src_out, // Peripheral outputs by source code
	input wire logic [N_SRC-1:0] i_src_ovr_en, // Source drives its own enable
	input wire logic [N_SRC-1:0] i_src_oe, // Enable from overriding source
	input wire logic [1:0] i_i2c_mode, // Sync serial units in I2C mode
	output logic [N_IN-1:0] o_periph_in, // Routed peripheral inputs
	output logic [N_PIN-1:0] o_pin_out, // Routed pin output data
	output logic [N_PIN-1:0] o_pin_oe, // Pin output driver enable
	output logic [N_PIN-1:0] o_pin_i2c_buf, // Dedicated I2C buffer in use
	output logic [N_PIN-1:0] o_pin_st_sel // Schmitt thresholds on general buffer
);
	localparam logic [N_IN*6-1:0] IN_DEF = `PRM_IN_DEFAULTS;
	localparam logic [N_IN*3-1:0] IN_PORTS = `PRM_IN_PORTS;
	localparam logic [N_PIN-1:0] I2C_PINS = `PRM_I2C_PIN_MASK;

	prm_pkg::prm_in_sel_t in_sel [N_IN];
	prm_pkg::prm_out_sel_t out_sel [N_PIN];
	prm_pkg::prm_seq_t seq;
	logic lock_flag;
	logic perm_lock;
	logic wr_lock;
	logic flag_write;
	logic [`PRM_DW-1:0] next_rdata;
	logic [N_IN-1:0] next_periph_in;
	logic [N_PIN-1:0] next_pin_out;
	logic [N_PIN-1:0] next_pin_oe;
	logic [N_PIN-1:0] next_i2c;

	// Lock register decode
	assign wr_lock = link.cfg_wr && (link.cfg_addr == `PRM_LOCK_ADDR);
	// RULE15 third write
	assign flag_write = wr_lock && (seq == prm_pkg::SEQ_KEY2);

	// RULE15 key tracking
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || i_dev_rst) begin
			seq <= prm_pkg::SEQ_IDLE;
		end else if (link.cfg_wr) begin
			case (seq)
				prm_pkg::SEQ_IDLE: begin
					if (wr_lock && link.cfg_wdata == `PRM_KEY1) begin
						seq <= prm_pkg::SEQ_KEY1;
					end
				end
				prm_pkg::SEQ_KEY1: begin
					if (wr_lock && link.cfg_wdata == `PRM_KEY2) begin
						seq <= prm_pkg::SEQ_KEY2;
					end else if (wr_lock && link.cfg_wdata == `PRM_KEY1) begin
						seq <= prm_pkg::SEQ_KEY1;
					end else begin
						seq <= prm_pkg::SEQ_IDLE;
					end
				end
				default: begin
					seq <= prm_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	// RULE14 guarded flag update
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || i_dev_rst) begin
			lock_flag <= 1'b0;
		end else if (flag_write) begin
			if (link.cfg_wdata[`PRM_LOCK_BIT]) begin
				lock_flag <= 1'b1;
			end else if (!perm_lock) begin
				// RULE16 clear blocked
				lock_flag <= 1'b0;
			end
		end
	end

	// RULE16 permanent lock
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || i_dev_rst) begin
			perm_lock <= 1'b0;
		end else if (flag_write && link.cfg_wdata[`PRM_LOCK_BIT] && i_one_shot_lock_cfg) begin
			perm_lock <= 1'b1;
		end
	end

	// RULE1 input selector storage
	for (genvar i = 0; i < N_IN; i++) begin : g_in_reg
		always_ff @(posedge i_sys_clk) begin
			// RULE17 defaults on power-on
			if (i_srst) begin
				in_sel[i] <= IN_DEF[i*6 +: 6];
			// RULE13 RULE18 locked writes dropped
			end else if (link.cfg_wr && !lock_flag && link.cfg_addr == (`PRM_IN_BASE + 8'(i))) begin
				in_sel[i] <= link.cfg_wdata[`PRM_IN_W-1:0];
			end
		end
	end

	// RULE4 RULE8 output selector storage
	for (genvar p = 0; p < N_PIN; p++) begin : g_out_reg
		always_ff @(posedge i_sys_clk) begin
			if (i_srst) begin
				out_sel[p] <= `PRM_OUT_DEFAULT;
			// RULE13 RULE18 locked writes dropped
			end else if (link.cfg_wr && !lock_flag && link.cfg_addr == (`PRM_OUT_BASE + 8'(p))) begin
				out_sel[p] <= link.cfg_wdata[`PRM_OUT_W-1:0];
			end
		end
	end

	// Read-back mux, unmapped addresses read zero
	always_comb begin
		next_rdata = '0;
		if (link.cfg_addr == `PRM_LOCK_ADDR) begin
			next_rdata[`PRM_LOCK_BIT] = lock_flag;
		end
		for (int i = 0; i < N_IN; i++) begin
			if (link.cfg_addr == (`PRM_IN_BASE + 8'(i))) begin
				next_rdata = {2'h0, in_sel[i]};
			end
		end
		for (int p = 0; p < N_PIN; p++) begin
			if (link.cfg_addr == (`PRM_OUT_BASE + 8'(p))) begin
				next_rdata = {3'h0, out_sel[p]};
			end
		end
	end

	// Read data stand one cycle after the strobe only
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || !link.cfg_rd) begin
			link.cfg_rdata <= '0;
		end else begin
			link.cfg_rdata <= next_rdata;
		end
	end

	// Lock state seen by the controller
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			link.lock_flag <= 1'b0;
		end else begin
			link.lock_flag <= lock_flag;
		end
	end

	// RULE7 digital-only input routing
	always_comb begin
		next_periph_in = '0;
		for (int i = 0; i < N_IN; i++) begin
			// RULE2 RULE19 linear code, unsupported reads zero
			if (in_sel[i] <= `PRM_PIN_LAST && IN_PORTS[i*3 + int'(in_sel[i][4:3])]) begin
				next_periph_in[i] = i_pin_in[in_sel[i][4:0]];
			end
		end
	end

	// RULE5 RULE6 output data and driver enable
	always_comb begin
		next_pin_out = i_pin_latch;
		next_pin_oe = ~i_pin_dir;
		for (int p = 0; p < N_PIN; p++) begin
			if (out_sel[p] != 5'h00 && int'(out_sel[p]) < N_SRC) begin
				next_pin_out[p] = i_src_out[out_sel[p]];
				if (i_src_ovr_en[out_sel[p]]) begin
					next_pin_oe[p] = i_src_oe[out_sel[p]];
				end
			end
		end
	end

	// RULE10 dedicated buffer only where implemented
	always_comb begin
		next_i2c = '0;
		for (int p = 0; p < N_PIN; p++) begin
			if (I2C_PINS[p]) begin
				next_i2c[p] = (i_i2c_mode[0] && (int'(in_sel[`PRM_I2C0_CLK_IDX]) == p
					|| int'(in_sel[`PRM_I2C0_DAT_IDX]) == p))
					|| (i_i2c_mode[1] && (int'(in_sel[`PRM_I2C1_CLK_IDX]) == p
					|| int'(in_sel[`PRM_I2C1_DAT_IDX]) == p));
			end
		end
	end

	// Registered routing outputs
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_periph_in <= '0;
			o_pin_out <= '0;
			o_pin_oe <= '0;
			o_pin_i2c_buf <= '0;
			o_pin_st_sel <= '0;
		end else begin
			o_periph_in <= next_periph_in;
			o_pin_out <= next_pin_out;
			o_pin_oe <= next_pin_oe;
			o_pin_i2c_buf <= next_i2c;
			// RULE11 input level ignored on I2C pins
			o_pin_st_sel <= i_input_level_select & ~next_i2c;
		end
	end
endmodule // prm_device
`default_nettype wire

/* src/prm_host.sv */
`include "prm_cfg.svh"
`default_nettype none
module prm_host (
	input wire logic i_sys_clk, // System clock
	input wire logic i_srst, // Reset, sync, high
	input wire logic [7:0] i_addr, // Controller register address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rdata, // Read data, cycle after strobe
	prm_if.host link // Register link to device
);
	localparam logic [`PRM_N_PIN-1:0] I2C_PINS = `PRM_I2C_PIN_MASK;

	prm_pkg::prm_host_t state;
	logic [7:0] tgt;
	logic [7:0] data;
	logic [4:0] src;
	logic [7:0] rd_cap;
	logic lock_op;
	logic refused;
	logic i2c_adv;
	logic cmd_go;
	logic bad_int;
	logic i2c_tgt;
	logic [7:0] next_rdata;

	// Command accepted only when idle
	assign cmd_go = i_wr && i_addr == `PRM_H_CMD && state == prm_pkg::H_IDLE;
	// RULE3 interrupt selector range
	assign bad_int = tgt == (`PRM_IN_BASE + 8'(`PRM_INT_IDX)) && data > `PRM_INT_LAST;
	assign i2c_tgt = tgt == (`PRM_IN_BASE + 8'(`PRM_I2C0_CLK_IDX)) || tgt == (`PRM_IN_BASE + 8'(`PRM_I2C0_DAT_IDX))
		|| tgt == (`PRM_IN_BASE + 8'(`PRM_I2C1_CLK_IDX)) || tgt == (`PRM_IN_BASE + 8'(`PRM_I2C1_DAT_IDX));

	// Software-loaded operands
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			tgt <= '0;
			data <= '0;
			src <= '0;
		end else if (i_wr && i_addr == `PRM_H_TGT) begin
			tgt <= i_wdata;
		end else if (i_wr && i_addr == `PRM_H_DATA) begin
			data <= i_wdata;
		end else if (i_wr && i_addr == `PRM_H_SRC) begin
			src <= i_wdata[4:0];
		end
	end

	// Command checks latched at acceptance
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			refused <= 1'b0;
			i2c_adv <= 1'b0;
		end else if (cmd_go && (i_wdata[`PRM_CMD_WRITE] || i_wdata[`PRM_CMD_PAIR])) begin
			refused <= bad_int;
			// RULE12 advisory on non-dedicated pin
			i2c_adv <= i2c_tgt && (data > 8'(`PRM_PIN_LAST) || !I2C_PINS[data[4:0]]);
		end
	end

	// Link sequencer
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state <= prm_pkg::H_IDLE;
			link.cfg_wr <= 1'b0;
			link.cfg_rd <= 1'b0;
			link.cfg_addr <= '0;
			link.cfg_wdata <= '0;
			lock_op <= 1'b0;
			rd_cap <= '0;
		end else begin
			link.cfg_wr <= 1'b0;
			link.cfg_rd <= 1'b0;
			case (state)
				prm_pkg::H_IDLE: begin
					if (cmd_go && (i_wdata[`PRM_CMD_LOCK] || i_wdata[`PRM_CMD_UNLOCK])) begin
						// RULE14 RULE15 first key
						lock_op <= i_wdata[`PRM_CMD_LOCK];
						link.cfg_wr <= 1'b1;
						link.cfg_addr <= `PRM_LOCK_ADDR;
						link.cfg_wdata <= `PRM_KEY1;
						state <= prm_pkg::H_KEY1;
					end else if (cmd_go && i_wdata[`PRM_CMD_READ]) begin
						link.cfg_rd <= 1'b1;
						link.cfg_addr <= tgt;
						state <= prm_pkg::H_RWAIT;
					end else if (cmd_go && (i_wdata[`PRM_CMD_WRITE] || i_wdata[`PRM_CMD_PAIR]) && !bad_int) begin
						link.cfg_wr <= 1'b1;
						link.cfg_addr <= tgt;
						link.cfg_wdata <= data;
						state <= i_wdata[`PRM_CMD_PAIR] ? prm_pkg::H_PAIR : prm_pkg::H_IDLE;
					end
				end
				prm_pkg::H_KEY1: begin
					link.cfg_wr <= 1'b1;
					link.cfg_wdata <= `PRM_KEY2;
					state <= prm_pkg::H_KEY2;
				end
				prm_pkg::H_KEY2: begin
					// RULE15 flag write right after keys
					link.cfg_wr <= 1'b1;
					link.cfg_wdata <= {7'h00, lock_op};
					state <= prm_pkg::H_IDLE;
				end
				prm_pkg::H_PAIR: begin
					// RULE9 output selector of same pin
					link.cfg_wr <= 1'b1;
					link.cfg_addr <= `PRM_OUT_BASE + {3'h0, data[4:0]};
					link.cfg_wdata <= {3'h0, src};
					state <= prm_pkg::H_IDLE;
				end
				prm_pkg::H_RWAIT: begin
					state <= prm_pkg::H_RCAP;
				end
				prm_pkg::H_RCAP: begin
					rd_cap <= link.cfg_rdata;
					state <= prm_pkg::H_IDLE;
				end
				default: begin
					state <= prm_pkg::H_IDLE;
				end
			endcase
		end
	end

	// Controller read-back
	always_comb begin
		next_rdata = '0;
		case (i_addr)
			`PRM_H_TGT: next_rdata = tgt;
			`PRM_H_DATA: next_rdata = data;
			`PRM_H_SRC: next_rdata = {3'h0, src};
			`PRM_H_STAT: begin
				next_rdata[`PRM_ST_BUSY] = state != prm_pkg::H_IDLE;
				next_rdata[`PRM_ST_LOCKED] = link.lock_flag;
				next_rdata[`PRM_ST_REFUSED] = refused;
				next_rdata[`PRM_ST_I2C_ADV] = i2c_adv;
			end
			`PRM_H_RDATA: next_rdata = rd_cap;
			default: next_rdata = '0;
		endcase
	end

	// Read data for one cycle only
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || !i_rd) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= next_rdata;
		end
	end
endmodule // prm_host
`default_nettype wire

/* dv/prm_link_assertions.sv */
`include "prm_cfg.svh"
`default_nettype none
module prm_link_assertions (
	input wire logic i_sys_clk, // System clock
	input wire logic i_srst, // Any reset, high
	input wire logic cfg_wr, // Write strobe
	input wire logic cfg_rd, // Read strobe
	input wire logic [`PRM_AW-1:0] cfg_addr, // Address
	input wire logic [`PRM_DW-1:0] cfg_wdata, // Write data
	input wire logic [`PRM_DW-1:0] cfg_rdata, // Read data
	input wire logic lock_flag // Lock flag copy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// Decode of selector address ranges
	logic in_a;
	logic out_a;
	assign in_a = cfg_addr >= `PRM_IN_BASE && cfg_addr <= 8'h36;
	assign out_a = cfg_addr >= `PRM_OUT_BASE && cfg_addr <= 8'h57;
	property p_excl;
		!(cfg_wr && cfg_rd);
	endproperty
	a_excl: assert property (p_excl) else $error("link strobes overlap");
	property p_idle;
		!cfg_rd |=> cfg_rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside its slot");
	property p_lkrd;
		cfg_rd && cfg_addr == `PRM_LOCK_ADDR |=> cfg_rdata == {7'h00, lock_flag};
	endproperty
	a_lkrd: assert property (p_lkrd) else $error("lock read wrong");
	property p_inrd;
		cfg_rd && in_a |=> cfg_rdata[7:6] == 2'h0;
	endproperty
	a_inrd: assert property (p_inrd) else $error("input selector read too wide");
	property p_outrd;
		cfg_rd && out_a |=> cfg_rdata[7:5] == 3'h0;
	endproperty
	a_outrd: assert property (p_outrd) else $error("output selector read too wide");
	property p_unmap;
		cfg_rd && !in_a && !out_a && cfg_addr != 8'h00 |=> cfg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	// A reset also moves the copy, up to two cycles after it was sampled
	property p_chg;
		!$stable(lock_flag) |-> $past(i_srst) || $past(i_srst, 2)
			|| ($past(cfg_wr, 2) && $past(cfg_addr, 2) == `PRM_LOCK_ADDR);
	endproperty
	a_chg: assert property (p_chg) else $error("lock flag moved without write");
	property p_keys;
		$rose(lock_flag) |-> $past(cfg_wdata[0], 2) && $past(cfg_wdata, 3) == `PRM_KEY2
			&& $past(cfg_wdata, 4) == `PRM_KEY1;
	endproperty
	a_keys: assert property (p_keys) else $error("lock set without key sequence");
	property p_rst;
		$fell(i_srst) |-> !lock_flag;
	endproperty
	a_rst: assert property (p_rst) else $error("lock flag survived reset");
endmodule // prm_link_assertions
`default_nettype wire

/* dv/tb.sv */
`include "prm_cfg.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [137:0] DEF = `PRM_IN_DEFAULTS;
	localparam logic [68:0] ALW = `PRM_IN_PORTS;
	localparam logic [23:0] I2P = `PRM_I2C_PIN_MASK;
	logic i_sys_clk = 1'h0;
	logic i_srst = 1'h1;
	logic dev_rst, one_shot, wr, rd;
	logic [7:0] addr, wdata, rdata;
	logic [23:0] pin_in, latch, dir, ils, pin_out, pin_oe, i2c_buf, st_sel;
	logic [27:0] src, ovr, soe;
	logic [1:0] mode;
	logic [22:0] periph_in;
	logic [5:0] m_in [23];
	logic [4:0] m_out [24];
	logic m_lock, m_perm;
	logic [7:0] ta [5] = '{8'h00, 8'h20, 8'h37, 8'h58, 8'hFF};
	int mismatches, total_checks, cyc, k;
	logic [7:0] t;
	prm_if u_prm_if ();
	always #10 i_sys_clk = ~i_sys_clk;
	prm_host u_prm_host (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .link(u_prm_if.host));
	prm_device u_prm_device (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_dev_rst(dev_rst),
		.i_one_shot_lock_cfg(one_shot), .link(u_prm_if.device), .i_pin_in(pin_in), .i_pin_latch(latch),
		.i_pin_dir(dir), .i_input_level_select(ils), .i_src_out(src), .i_src_ovr_en(ovr), .i_src_oe(soe),
		.i_i2c_mode(mode), .o_periph_in(periph_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
		.o_pin_i2c_buf(i2c_buf), .o_pin_st_sel(st_sel));
	prm_link_assertions u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst | dev_rst), .cfg_wr(u_prm_if.cfg_wr),
		.cfg_rd(u_prm_if.cfg_rd), .cfg_addr(u_prm_if.cfg_addr), .cfg_wdata(u_prm_if.cfg_wdata),
		.cfg_rdata(u_prm_if.cfg_rdata), .lock_flag(u_prm_if.lock_flag));
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Bus cycle helpers on the controller port
	task automatic bw(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge i_sys_clk);
		wr <= 1'h0;
	endtask
	task automatic br(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge i_sys_clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask
	// Issue one command and track it in the model
	task automatic put(input logic [7:0] t, d, s, c);
		bw(`PRM_H_TGT, t);
		bw(`PRM_H_DATA, d);
		bw(`PRM_H_SRC, s);
		bw(`PRM_H_CMD, c);
		repeat (6) @(posedge i_sys_clk);
		if (c == 8'h04) begin
			m_lock = 1'h1;
			m_perm = m_perm | one_shot;
		end else if (c == 8'h08) begin
			m_lock = m_perm;
		end else if ((c == 8'h01 || c == 8'h10) && !m_lock && !(t == 8'h20 && d > 8'h0F)) begin
			if (t >= 8'h20 && t <= 8'h36) m_in[t-8'h20] = d[5:0];
			if (t >= 8'h40 && t <= 8'h57) m_out[t-8'h40] = d[4:0];
			if (c == 8'h10) m_out[d[4:0]] = s[4:0];
		end
	endtask
	function automatic logic [7:0] rdexp(input logic [7:0] t);
		if (t == 8'h00) return {7'h00, m_lock};
		if (t >= 8'h20 && t <= 8'h36) return {2'h0, m_in[t-8'h20]};
		if (t >= 8'h40 && t <= 8'h57) return {3'h0, m_out[t-8'h40]};
		return 8'h00;
	endfunction
	task automatic tst(input logic [7:0] t);
		logic [7:0] r;
		put(t, 8'h00, 8'h00, 8'h02);
		br(`PRM_H_RDATA, r);
		check("readback", 32'(r), 32'(rdexp(t)));
	endtask
	task automatic lk();
		logic [7:0] r;
		br(`PRM_H_STAT, r);
		check("locked", 32'(r[1]), 32'(m_lock));
	endtask
	task automatic rst_model();
		for (int i = 0; i < 23; i++) m_in[i] = DEF[i*6+:6];
		for (int p = 0; p < 24; p++) m_out[p] = `PRM_OUT_DEFAULT;
		m_lock = 1'h0;
		m_perm = 1'h0;
	endtask
	task automatic rnd();
		@(posedge i_sys_clk);
		pin_in <= 24'($urandom);
		latch <= 24'($urandom);
		dir <= 24'($urandom);
		ils <= 24'($urandom);
		src <= 28'($urandom);
		ovr <= 28'($urandom);
		soe <= 28'($urandom);
		mode <= 2'($urandom);
	endtask
	// Compare every routed output against the model
	task automatic chk();
		logic [22:0] ei;
		logic [23:0] eo, ee, eb, es;
		logic [5:0] c;
		logic [4:0] o;
		repeat (3) @(posedge i_sys_clk);
		#1;
		for (int i = 0; i < 23; i++) begin
			c = m_in[i];
			ei[i] = (c <= 6'h17 && ALW[i*3+c[4:3]]) ? pin_in[c] : 1'h0;
		end
		for (int p = 0; p < 24; p++) begin
			o = m_out[p];
			eo[p] = (o == 0 || o >= 28) ? latch[p] : src[o];
			ee[p] = (o != 0 && o < 28 && ovr[o]) ? soe[o] : !dir[p];
			eb[p] = I2P[p] && ((mode[0] && (m_in[13] == p || m_in[14] == p))
				|| (mode[1] && (m_in[16] == p || m_in[17] == p)));
			es[p] = ils[p] && !eb[p];
		end
		check("periph_in", 32'(periph_in), 32'(ei));
		check("pin_out", 32'(pin_out), 32'(eo));
		check("pin_oe", 32'(pin_oe), 32'(ee));
		check("i2c_buf", 32'(i2c_buf), 32'(eb));
		check("st_sel", 32'(st_sel), 32'(es));
	endtask
	// Cut a hung run short
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		logic [7:0] r;
		void'($urandom(32'h2289));
		{dev_rst, one_shot, wr, rd, addr, wdata} = '0;
		{pin_in, latch, dir, ils, src, ovr, soe, mode} = '0;
		rst_model();
		repeat (16) @(posedge i_sys_clk);
		i_srst <= 1'h0;
		rnd();
		chk();
		repeat (40) begin
			rnd();
			k = $urandom_range(2, 0);
			t = k == 1 ? 8'h40 + 8'($urandom_range(23, 0)) : 8'h20 + 8'($urandom_range(22, 0));
			put(t, 8'($urandom_range(k == 2 ? 23 : 31, 0)), 8'($urandom_range(31, 0)), k == 2 ? 8'h10 : 8'h01);
			tst(t);
			chk();
		end
		put(8'h20, 8'h10, 8'h00, 8'h01);
		br(`PRM_H_STAT, r);
		check("refused", 32'(r[2]), 32'h1);
		put(8'h20, 8'h0F, 8'h00, 8'h01);
		br(`PRM_H_STAT, r);
		check("refused", 32'(r[2]), 32'h0);
		foreach (ta[j]) tst(ta[j]);
		put(8'h00, 8'h00, 8'h00, 8'h04);
		lk();
		rnd();
		put(8'h21, 8'h05, 8'h00, 8'h01);
		put(8'h23, 8'h03, 8'h0D, 8'h10);
		tst(8'h21);
		tst(8'h00);
		chk();
		put(8'h00, 8'h00, 8'h00, 8'h08);
		lk();
		put(8'h21, 8'h05, 8'h00, 8'h01);
		chk();
		put(8'h2D, 8'h05, 8'h00, 8'h01);
		br(`PRM_H_STAT, r);
		check("i2c_adv", 32'(r[3]), 32'(!I2P[5]));
		put(8'h2D, 8'h13, 8'h00, 8'h01);
		br(`PRM_H_STAT, r);
		check("i2c_adv", 32'(r[3]), 32'(!I2P[19]));
		chk();
		@(posedge i_sys_clk);
		one_shot <= 1'h1;
		put(8'h00, 8'h00, 8'h00, 8'h04);
		put(8'h00, 8'h00, 8'h00, 8'h08);
		lk();
		put(8'h42, 8'h07, 8'h00, 8'h01);
		chk();
		@(posedge i_sys_clk);
		dev_rst <= 1'h1;
		repeat (3) @(posedge i_sys_clk);
		dev_rst <= 1'h0;
		m_lock = 1'h0;
		m_perm = 1'h0;
		lk();
		chk();
		@(posedge i_sys_clk);
		i_srst <= 1'h1;
		repeat (2) @(posedge i_sys_clk);
		i_srst <= 1'h0;
		rst_model();
		chk();
		stop_test();
	end
endmodule // tb
`default_nettype wire
